/* src/io_pin_pkg.sv */
// Constants shared by the port banks and the pin steering top level
package io_pin_pkg;

	// Data and address widths of the register port
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int NUM_PORTS = 2;
	localparam int NUM_FUNCS = 8;
	localparam int PIN_IDX_W = 4;

	// Register offsets
	localparam logic [3:0] OFS_A_DIR = 4'h0;
	localparam logic [3:0] OFS_A_PIN = 4'h1;
	localparam logic [3:0] OFS_A_LAT = 4'h2;
	localparam logic [3:0] OFS_A_ANA = 4'h3;
	localparam logic [3:0] OFS_B_DIR = 4'h4;
	localparam logic [3:0] OFS_B_PIN = 4'h5;
	localparam logic [3:0] OFS_B_LAT = 4'h6;
	localparam logic [3:0] OFS_B_ANA = 4'h7;
	localparam logic [3:0] OFS_ALT = 4'h8;

	// Reset values
	localparam logic [7:0] DIR_RST = 8'hFF;
	localparam logic [7:0] LAT_RST = 8'h00;
	localparam logic [7:0] ANA_RST = 8'h00;
	localparam logic [7:0] ALT_RST = 8'h00;
	localparam logic [7:0] RD_IDLE = 8'h00;

	// Port A pin 5 is input only and its direction bit reads one
	localparam logic [7:0] A_INPUT_ONLY = 8'h20;
	localparam logic [7:0] B_INPUT_ONLY = 8'h00;

	// Select bits that exist only on the larger variant
	localparam logic [7:0] ALT_LARGE_ONLY = 8'h18;

	// Select bit positions, one per steered function
	localparam int SEL_CAPCOMP1 = 0;
	localparam int SEL_PWM1_C = 1;
	localparam int SEL_PWM1_D = 2;
	localparam int SEL_CAPCOMP2 = 3;
	localparam int SEL_PWM2_B = 4;
	localparam int SEL_SLAVE_SEL = 5;
	localparam int SEL_SERIAL_OUT = 6;
	localparam int SEL_RX_DATA = 7;

	// Pin index per function, bit 7 first; 0..7 port A, 8..15 port B
	localparam logic [7:0][3:0] DEF_PIN = {4'h9, 4'hA, 4'hD, 4'hF, 4'hE, 4'hF, 4'hE, 4'hB};
	localparam logic [7:0][3:0] ALT_PIN = {4'hA, 4'h6, 4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h8};

	// Pin synchroniser depth
	localparam int SYNC_STAGES = 3;

endpackage : io_pin_pkg

/* src/io_port_bank.sv */
// One general purpose port: direction, latch, analog select and pin sampling
`timescale 1ns/1ps
module io_port_bank #(
	parameter int         WIDTH      = 8,
	parameter logic [7:0] INPUT_ONLY = 8'h00
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	// Register writes
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic             dir_we,
	input  wire logic             lat_we,
	input  wire logic             ana_we,
	// Peripheral overrides
	input  wire logic [WIDTH-1:0] ovr_en,
	input  wire logic [WIDTH-1:0] ovr_drive,
	input  wire logic [WIDTH-1:0] ovr_val,
	// Pins
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe_n,
	// Register state
	output logic      [WIDTH-1:0] dir_q,
	output logic      [WIDTH-1:0] lat_q,
	output logic      [WIDTH-1:0] ana_q,
	output logic      [WIDTH-1:0] pin_digital
);

	logic [WIDTH-1:0] dir_reg;
	logic [WIDTH-1:0] lat_reg;
	logic [WIDTH-1:0] ana_reg;
	logic [WIDTH-1:0] sync1_reg;
	logic [WIDTH-1:0] sync2_reg;
	logic [WIDTH-1:0] sync3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] pin_out_next;
	logic [WIDTH-1:0] pin_oe_n_next;
	logic [WIDTH-1:0] level_next;

	// Steered peripheral wins; otherwise a clear direction bit drives the latch, except on input-only pins
	assign pin_out_next  = (ovr_en & ovr_val) | (~ovr_en & lat_reg);
	assign pin_oe_n_next = (ovr_en & ~ovr_drive) | (~ovr_en & (dir_reg | INPUT_ONLY[WIDTH-1:0]));
	// A new level is taken once the second and third stages agree
	assign level_next    = (sync2_reg & sync3_reg) | (level_reg & (sync2_reg ^ sync3_reg));

	// Software registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dir_reg <= io_pin_pkg::DIR_RST[WIDTH-1:0];
			lat_reg <= io_pin_pkg::LAT_RST[WIDTH-1:0];
			ana_reg <= io_pin_pkg::ANA_RST[WIDTH-1:0];
		end else begin
			if (dir_we) dir_reg <= wdata;
			if (lat_we) lat_reg <= wdata;
			if (ana_we) ana_reg <= wdata;
		end
	end

	// Pin sampling and registered pin drive
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			level_reg <= '0;
			pin_out   <= '0;
			pin_oe_n  <= '1;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= level_next;
			pin_out   <= pin_out_next;
			pin_oe_n  <= pin_oe_n_next;
		end
	end

	// Input-only pins report their direction bit as one
	assign dir_q       = dir_reg | INPUT_ONLY[WIDTH-1:0];
	assign lat_q       = lat_reg;
	assign ana_q       = ana_reg;
	// Analog pins read zero digitally
	assign pin_digital = level_reg & ~ana_reg;

endmodule : io_port_bank

/* src/io_port_alt_pin_steering.sv */
// Two general purpose ports with alternate pin steering of peripheral functions
//
// Overview of operation
// - Two ports, A and B, each eight pins wide.
// - An enabled peripheral takes control of its selected pin; on a shared pin the lower select bit wins.
// - Each port has direction, pin level and output latch registers.
// - Writing the pin level register writes the output latch, same as latch.
// - Latch reads return latch contents; pin level reads return sampled pins.
// - Analog select register per port disables digital input of its pins.
// - Select bits route each steered function to one of two pins.
// - Select bit writes never change any direction register.
// - Overrides follow the selected pin; the other pin stays a normal port pin.
// - Bit 5 puts slave select on RB5 when clear, RA5 when set.
// - Direction one makes an input; zero drives the latch onto the pin, except on input-only RA5.
// - Analog selected pins read zero digitally; digital output unaffected.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module io_port_alt_pin_steering #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// Register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Steered peripheral functions, indexed by select bit
	input  wire logic [7:0] func_enable,
	input  wire logic [7:0] func_drive,
	input  wire logic [7:0] func_out,
	output logic      [7:0] func_in,
	// Port A pins
	input  wire logic [7:0] port_a_in,
	output logic      [7:0] port_a_out,
	output logic      [7:0] port_a_oe_n,
	// Port B pins
	input  wire logic [7:0] port_b_in,
	output logic      [7:0] port_b_out,
	output logic      [7:0] port_b_oe_n,
	// Current select setting
	output logic      [7:0] alt_select
);

	// Register state
	logic [7:0]  alt_function_select_reg;
	logic [7:0]  alt_function_select_next;
	logic [7:0]  reg_rdata_reg;
	logic [7:0]  reg_rdata_next;

	// Bank views
	logic [7:0]  a_dir;
	logic [7:0]  a_lat;
	logic [7:0]  a_ana;
	logic [7:0]  a_pin;
	logic [7:0]  b_dir;
	logic [7:0]  b_lat;
	logic [7:0]  b_ana;
	logic [7:0]  b_pin;

	// Override vectors over all sixteen pins
	logic [15:0] ovr_en;
	logic [15:0] ovr_drive;
	logic [15:0] ovr_val;
	logic [15:0] pin_digital_all;

	// Address decode
	wire hit_a_dir = (reg_addr == io_pin_pkg::OFS_A_DIR);
	wire hit_a_pin = (reg_addr == io_pin_pkg::OFS_A_PIN);
	wire hit_a_lat = (reg_addr == io_pin_pkg::OFS_A_LAT);
	wire hit_a_ana = (reg_addr == io_pin_pkg::OFS_A_ANA);
	wire hit_b_dir = (reg_addr == io_pin_pkg::OFS_B_DIR);
	wire hit_b_pin = (reg_addr == io_pin_pkg::OFS_B_PIN);
	wire hit_b_lat = (reg_addr == io_pin_pkg::OFS_B_LAT);
	wire hit_b_ana = (reg_addr == io_pin_pkg::OFS_B_ANA);
	wire hit_alt   = (reg_addr == io_pin_pkg::OFS_ALT);

	// Write strobes per bank register
	wire a_dir_we = reg_wr & hit_a_dir;
	wire a_lat_we = reg_wr & (hit_a_lat | hit_a_pin);
	wire a_ana_we = reg_wr & hit_a_ana;
	wire b_dir_we = reg_wr & hit_b_dir;
	wire b_lat_we = reg_wr & (hit_b_lat | hit_b_pin);
	wire b_ana_we = reg_wr & hit_b_ana;
	wire alt_we   = reg_wr & hit_alt;

	// Bits that exist on this variant
	wire [7:0] alt_mask = LARGE_VARIANT ? 8'hFF : ~io_pin_pkg::ALT_LARGE_ONLY;

	// Select register next value; it has no path into any direction bit
	assign alt_function_select_next = alt_we ? (reg_wdata & alt_mask) : alt_function_select_reg;

	// Read data selection; unmapped offsets read zero
	assign reg_rdata_next =
		!reg_rd   ? io_pin_pkg::RD_IDLE :
		hit_a_dir ? a_dir :
		hit_a_pin ? a_pin :
		hit_a_lat ? a_lat :
		hit_a_ana ? a_ana :
		hit_b_dir ? b_dir :
		hit_b_pin ? b_pin :
		hit_b_lat ? b_lat :
		hit_b_ana ? b_ana :
		hit_alt   ? alt_function_select_reg :
		io_pin_pkg::RD_IDLE;

	// Select register and read data
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			alt_function_select_reg <= io_pin_pkg::ALT_RST;
			reg_rdata_reg           <= io_pin_pkg::RD_IDLE;
		end else begin
			alt_function_select_reg <= alt_function_select_next;
			reg_rdata_reg           <= reg_rdata_next;
		end
	end

	assign reg_rdata  = reg_rdata_reg;
	assign alt_select = alt_function_select_reg;

	// Pin chosen for each function by its select bit
	logic [7:0][3:0] func_pin;

	// Default pin when the bit is clear, alternate pin when set
	always_comb begin
		for (int f = 0; f < io_pin_pkg::NUM_FUNCS; f++) begin
			func_pin[f] = alt_function_select_reg[f] ? io_pin_pkg::ALT_PIN[f] : io_pin_pkg::DEF_PIN[f];
		end
	end

	// Overrides land only on the selected pin; lower select bit wins a shared pin
	always_comb begin
		ovr_en    = 16'h0000;
		ovr_drive = 16'h0000;
		ovr_val   = 16'h0000;
		for (int f = io_pin_pkg::NUM_FUNCS - 1; f >= 0; f--) begin
			if (func_enable[f]) begin
				ovr_en[func_pin[f]]    = 1'b1;
				ovr_drive[func_pin[f]] = func_drive[f];
				ovr_val[func_pin[f]]   = func_out[f];
			end
		end
	end

	// Inputs to peripherals come from their selected pin only
	assign pin_digital_all = {b_pin, a_pin};

	always_comb begin
		for (int f = 0; f < io_pin_pkg::NUM_FUNCS; f++) begin
			func_in[f] = func_enable[f] & pin_digital_all[func_pin[f]];
		end
	end

	// Port A
	io_port_bank #(
		.WIDTH      (io_pin_pkg::DATA_W),
		.INPUT_ONLY (io_pin_pkg::A_INPUT_ONLY)
	) u_port_a (
		.ref_clk     (ref_clk),
		.arst_n      (arst_n),
		.wdata       (reg_wdata),
		.dir_we      (a_dir_we),
		.lat_we      (a_lat_we),
		.ana_we      (a_ana_we),
		.ovr_en      (ovr_en[7:0]),
		.ovr_drive   (ovr_drive[7:0]),
		.ovr_val     (ovr_val[7:0]),
		.pin_in      (port_a_in),
		.pin_out     (port_a_out),
		.pin_oe_n    (port_a_oe_n),
		.dir_q       (a_dir),
		.lat_q       (a_lat),
		.ana_q       (a_ana),
		.pin_digital (a_pin)
	);

	// Port B
	io_port_bank #(
		.WIDTH      (io_pin_pkg::DATA_W),
		.INPUT_ONLY (io_pin_pkg::B_INPUT_ONLY)
	) u_port_b (
		.ref_clk     (ref_clk),
		.arst_n      (arst_n),
		.wdata       (reg_wdata),
		.dir_we      (b_dir_we),
		.lat_we      (b_lat_we),
		.ana_we      (b_ana_we),
		.ovr_en      (ovr_en[15:8]),
		.ovr_drive   (ovr_drive[15:8]),
		.ovr_val     (ovr_val[15:8]),
		.pin_in      (port_b_in),
		.pin_out     (port_b_out),
		.pin_oe_n    (port_b_oe_n),
		.dir_q       (b_dir),
		.lat_q       (b_lat),
		.ana_q       (b_ana),
		.pin_digital (b_pin)
	);

endmodule : io_port_alt_pin_steering

/* bench/io_pin_checker.sv */
// Port-level assertions for the pin steering block
`timescale 1ns/1ps
module io_pin_checker (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       arst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Peripherals and pins
	input wire logic [7:0] func_enable,
	input wire logic [7:0] func_drive,
	input wire logic [7:0] func_out,
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_a_oe_n,
	input wire logic [7:0] port_b_out,
	input wire logic [7:0] port_b_oe_n,
	input wire logic [7:0] alt_select
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Select register write decode
	wire alt_wr = reg_wr && reg_addr == 4'h8;
	// Register port and select register
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
	sel_write_a: assert property (alt_wr |=> alt_select == $past(reg_wdata)) else $error("select not written");
	sel_hold_a: assert property (!alt_wr |=> $stable(alt_select)) else $error("select changed");
	unmapped_read_a: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 8'h00) else $error("unmapped");
	// Steered outputs follow the selected pin
	serial_def_a: assert property (func_enable[6] && func_drive[6] && !alt_select[6] |=>
		!port_b_oe_n[2] && port_b_out[2] == $past(func_out[6])) else $error("serial out on RB2");
	serial_alt_a: assert property (func_enable[6] && func_drive[6] && func_enable[4:2] == 3'h0 && alt_select[6]
		|=> !port_a_oe_n[6] && port_a_out[6] == $past(func_out[6])) else $error("serial out on RA6");
	capcomp_alt_a: assert property (func_enable[0] && func_drive[0] && alt_select[0] |=>
		!port_b_oe_n[0] && port_b_out[0] == $past(func_out[0])) else $error("capcomp on RB0");
	input_turn_a: assert property (func_enable[0] && !func_drive[0] && !alt_select[0] |=> port_b_oe_n[3])
		else $error("RB3 driven");
	// Main scenarios
	cover property (alt_wr);
	cover property (func_enable[6] && alt_select[6]);
	cover property (reg_rd && reg_addr == 4'h5);
endmodule : io_pin_checker

bind io_port_alt_pin_steering io_pin_checker io_pin_checker_i (.*);

/* bench/pin_pad_model.sv */
// Package pads: driven by the block, by outside sources, or left floating
`timescale 1ns/1ps
module pin_pad_model (
	// Clock
	input  wire logic        ref_clk,
	// Block side
	input  wire logic [15:0] pad_out,
	input  wire logic [15:0] pad_oe_n,
	// Outside sources
	input  wire logic [15:0] ext_en,
	input  wire logic [15:0] ext_val,
	// Resolved levels
	output logic      [15:0] pad_level
);
	logic float_reg = 1'b0;
	// A floating pad has no pull, so show a level that changes every cycle
	always_ff @(posedge ref_clk) float_reg <= ~float_reg;
	// Outside source first, then the block's driver, else floating
	assign pad_level = (ext_en & ext_val) | (~ext_en & ~pad_oe_n & pad_out) | (~ext_en & pad_oe_n & {16{float_reg}});
endmodule : pin_pad_model

/* bench/io_port_alt_pin_steering_test.sv */
// Self-checking bench for the pin steering block
`timescale 1ns/1ps
module io_port_alt_pin_steering_test;
	logic        ref_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	wire logic [7:0]  reg_rdata, func_in;
	logic [7:0]  func_enable = 8'h00;
	logic [7:0]  func_drive = 8'h00;
	logic [7:0]  func_out = 8'h00;
	wire logic [15:0] pad_out, pad_oe_n, pad_level;
	logic [15:0] ext_en = 16'h0000;
	logic [15:0] ext_val = 16'h0000;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cycles = 0;
	int          p, q;
	// Pin per select bit, cleared then set; 0..7 port A, 8..15 port B
	int          pin_clr [8] = '{11, 14, 15, 14, 15, 13, 10, 9};
	int          pin_set [8] = '{8, 7, 6, 7, 6, 5, 6, 10};

	// Clock
	always #5 ref_clk = ~ref_clk;

	io_port_alt_pin_steering io_port_alt_pin_steering_i (
		.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .func_enable(func_enable), .func_drive(func_drive),
		.func_out(func_out), .func_in(func_in), .port_a_in(pad_level[7:0]), .port_a_out(pad_out[7:0]),
		.port_a_oe_n(pad_oe_n[7:0]), .port_b_in(pad_level[15:8]), .port_b_out(pad_out[15:8]),
		.port_b_oe_n(pad_oe_n[15:8]), .alt_select());
	pin_pad_model pin_pad_model_i (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_en(ext_en),
		.ext_val(ext_val), .pad_level(pad_level));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	// Cut a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			wrap_up();
		end
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(4'h0, 8'hFF);
		rd(4'h2, 8'h00);
		rd(4'h8, 8'h00);
		$display("reset test done");
		wr(4'h1, 8'h5A);
		rd(4'h2, 8'h5A);
		wr(4'h2, 8'hA5);
		rd(4'h6, 8'h00);
		wr(4'h0, 8'h00);
		rd(4'h0, 8'h20);
		wr(4'h3, 8'h81);
		rd(4'h3, 8'h81);
		ext_en <= 16'hFF20;
		ext_val <= 16'h3C20;
		tick(6);
		chk({pad_oe_n[7:0], pad_out[7:0] & 8'hDF}, 16'h2085);
		rd(4'h1, 8'h24);
		rd(4'h5, 8'h3C);
		wr(4'h9, 8'hFF);
		rd(4'h9, 8'h00);
		$display("port test done");
		wr(4'h8, 8'hFF);
		rd(4'h8, 8'hFF);
		rd(4'h0, 8'h20);
		rd(4'h4, 8'hFF);
		wr(4'h0, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			for (int s = 0; s < 2; s++) begin
				@(posedge ref_clk);
				func_enable <= 8'h01 << i;
				func_drive <= 8'h01 << i;
				func_out <= 8'h01 << i;
				wr(4'h8, 8'(s) << i);
				tick(2);
				p = s ? pin_set[i] : pin_clr[i];
				q = s ? pin_clr[i] : pin_set[i];
				chk({13'h0000, pad_out[p], pad_oe_n[p], pad_oe_n[q]}, 16'h0005);
			end
		end
		$display("steering test done");
		@(posedge ref_clk);
		func_enable <= 8'h20;
		func_drive <= 8'h00;
		ext_en <= 16'h2020;
		ext_val <= 16'h2000;
		wr(4'h8, 8'h00);
		tick(6);
		chk({8'h00, func_in}, 16'h0020);
		wr(4'h8, 8'h20);
		tick(6);
		chk({8'h00, func_in}, 16'h0000);
		$display("input steering test done");
		wrap_up();
	end
endmodule : io_port_alt_pin_steering_test
